// ==== logic/utc_pkg.sv ====
// package with register map, field layout and sizes of the up/down timer
package utc_pkg;
   // ****************************************
   // sizes
   // ****************************************
   localparam int UTC_CNT_W = 11;
   localparam int UTC_RTC_W = 22;
   localparam int UTC_ADDR_W = 8;
   localparam int UTC_DATA_W = 32;
   localparam int UTC_NUM_CH = 2;
   localparam int UTC_NUM_PIN = 12;
   localparam int UTC_SEL_W = 4;
   localparam int UTC_PER_W = 4;

   // ****************************************
   // register byte addresses
   // ****************************************
   localparam logic [7:0] UTC_ADDR_CTRL = 8'h00;
   localparam logic [7:0] UTC_ADDR_CAPTURE = 8'h04;
   localparam logic [7:0] UTC_ADDR_STATUS = 8'h08;
   localparam logic [7:0] UTC_ADDR_CLR_EVENT = 8'h0C;
   localparam logic [7:0] UTC_ADDR_CAPCNT1 = 8'h10;
   localparam logic [7:0] UTC_ADDR_CAPCNT2 = 8'h14;
   localparam logic [7:0] UTC_ADDR_COUNTER = 8'h18;

   // ****************************************
   // control register fields
   // ****************************************
   localparam int UTC_CTRL_RELOAD_LSB = 0;
   localparam int UTC_CTRL_DOWN_BIT = 11;
   localparam int UTC_CTRL_IRQ_EN_BIT = 12;
   localparam int UTC_CTRL_FREE_RUN_BIT = 13;
   localparam int UTC_CTRL_SYS_CLK_BIT = 14;
   localparam int UTC_CTRL_CLK_EN_BIT = 15;
   localparam int UTC_CTRL_ENABLE_BIT = 16;
   localparam int UTC_CTRL_W = 17;

   // ****************************************
   // capture config fields, channel n adds n or n * field width
   // ****************************************
   localparam int UTC_CAP_SEL_LSB = 0;
   localparam int UTC_CAP_FALL_BIT = 8;
   localparam int UTC_CAP_COUNT_EN_BIT = 10;
   localparam int UTC_CAP_IRQ_EN_BIT = 12;
   localparam int UTC_CAP_STAMP_BIT = 14;
   localparam int UTC_CAP_PER_LSB = 16;
   localparam int UTC_CAP_W = 24;

   // ****************************************
   // status and clear-event fields
   // ****************************************
   localparam int UTC_ST_EVENT_LSB = 0;
   localparam int UTC_ST_OVF_LSB = 2;
   localparam int UTC_ST_TIMER_BIT = 4;
   localparam int UTC_CLR_TIMER_BIT = 2;

   localparam logic [31:0] UTC_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] UTC_CAP_RESET = 32'h0000_0000;
endpackage

// ==== logic/utc_timer.sv ====
// up/down timer with two-channel edge counting and capture
`timescale 1ns/1ps
module utc_timer import utc_pkg::*; #(
   parameter int CNT_W = UTC_CNT_W,
   parameter int RTC_W = UTC_RTC_W
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [UTC_ADDR_W-1:0] reg_addr,
   input wire logic [UTC_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [UTC_DATA_W-1:0] reg_rdata,
   input wire logic low_power_clock,
   input wire logic [UTC_NUM_PIN-1:0] port0_pin,
   input wire logic [RTC_W-1:0] rtc_value,
   output logic irq
);

   // ****************************************
   // registers
   // ****************************************
   logic [UTC_CTRL_W-1:0] updown_timer_control_register;
   logic [UTC_CAP_W-1:0] edge_capture_config_register;
   logic [UTC_NUM_CH-1:0] channel_event_flag;
   logic [UTC_NUM_CH-1:0] channel_snapshot_overflow;
   logic timer_event_flag;
   logic [RTC_W-1:0] channel_capture_count_value [UTC_NUM_CH];
   logic [CNT_W-1:0] count;

   logic [CNT_W-1:0] reload_threshold;
   logic count_direction_down;
   logic timer_interrupt_enable;
   logic free_running_enable;
   logic system_clock_select;
   logic timer_clock_enable;
   logic timer_run_enable;
   logic running;
   logic tick;
   logic [UTC_NUM_CH-1:0] channel_event_clear;
   logic timer_event_clear;
   logic ctrl_wr;
   logic cap_wr;
   logic clr_wr;

   assign reload_threshold = updown_timer_control_register[UTC_CTRL_RELOAD_LSB +: CNT_W];
   assign count_direction_down = updown_timer_control_register[UTC_CTRL_DOWN_BIT];
   assign timer_interrupt_enable = updown_timer_control_register[UTC_CTRL_IRQ_EN_BIT];
   assign free_running_enable = updown_timer_control_register[UTC_CTRL_FREE_RUN_BIT];
   assign system_clock_select = updown_timer_control_register[UTC_CTRL_SYS_CLK_BIT];
   assign timer_clock_enable = updown_timer_control_register[UTC_CTRL_CLK_EN_BIT];
   assign timer_run_enable = updown_timer_control_register[UTC_CTRL_ENABLE_BIT];

   assign ctrl_wr = reg_wr && (reg_addr == UTC_ADDR_CTRL);
   assign cap_wr = reg_wr && (reg_addr == UTC_ADDR_CAPTURE);
   assign clr_wr = reg_wr && (reg_addr == UTC_ADDR_CLR_EVENT);
   assign channel_event_clear = clr_wr ? reg_wdata[UTC_NUM_CH-1:0] : '0;
   assign timer_event_clear = clr_wr && reg_wdata[UTC_CLR_TIMER_BIT];

   // ****************************************
   // software writes
   // ****************************************
   // only arst_n resets state; nothing depends on the processor domain
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         updown_timer_control_register <= UTC_CTRL_RESET[UTC_CTRL_W-1:0];
      end else if (ctrl_wr) begin
         updown_timer_control_register <= reg_wdata[UTC_CTRL_W-1:0];
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         edge_capture_config_register <= UTC_CAP_RESET[UTC_CAP_W-1:0];
      end else if (cap_wr) begin
         edge_capture_config_register <= reg_wdata[UTC_CAP_W-1:0];
      end
   end

   // ****************************************
   // timer clock: system clock, or low-power clock synchronised and edge detected
   // ****************************************
   logic lp_meta;
   logic lp_sync;
   logic lp_prev;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         lp_meta <= 1'b0;
         lp_sync <= 1'b0;
         lp_prev <= 1'b0;
      end else begin
         lp_meta <= low_power_clock;
         lp_sync <= lp_meta;
         lp_prev <= lp_sync;
      end
   end

   assign running = timer_clock_enable && timer_run_enable;
   assign tick = running && (system_clock_select || (lp_sync && !lp_prev));

   // ****************************************
   // main counter
   // ****************************************
   logic [CNT_W-1:0] next_count;
   logic reach;

   always_comb begin
      next_count = count;
      reach = 1'b0;
      if (!running) begin
         next_count = count_direction_down ? reload_threshold : '0;
      end else if (tick) begin
         if (count_direction_down) begin
            next_count = (count == '0) ? reload_threshold : count - 1'b1;
            reach = (next_count == '0) && (count != '0);
         end else if (free_running_enable) begin
            next_count = count + 1'b1; // wraps at all ones
            reach = (next_count == '0);
         end else begin
            next_count = (count == reload_threshold) ? '0 : count + 1'b1;
            reach = (next_count == reload_threshold) && (count != reload_threshold);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         timer_event_flag <= 1'b0;
      end else if (reach) begin
         timer_event_flag <= 1'b1;
      end else if (timer_event_clear) begin
         timer_event_flag <= 1'b0;
      end
   end

   // ****************************************
   // edge sense channels
   // ****************************************
   logic [UTC_NUM_PIN-1:0] pin_meta;
   logic [UTC_NUM_PIN-1:0] pin_sync;
   logic [UTC_NUM_PIN-1:0] pin_prev;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pin_meta <= '0;
         pin_sync <= '0;
         pin_prev <= '0;
      end else begin
         pin_meta <= port0_pin;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   logic [UTC_NUM_CH-1:0] ch_enabled_irq;

   genvar ch;
   generate
      for (ch = 0; ch < UTC_NUM_CH; ch++) begin : g_ch
         logic [UTC_SEL_W-1:0] channel_pin_select;
         logic [UTC_PER_W-1:0] period_max;
         logic falling_edge_select;
         logic count_mode_enable;
         logic interrupt_enable;
         logic snapshot_source;
         logic cur;
         logic prv;
         logic edge_seen;
         logic pending;
         logic [UTC_PER_W-1:0] edge_count;
         logic [RTC_W-1:0] cycle_count;
         logic group_done;
         logic take;
         logic [RTC_W-1:0] next_value;

         assign channel_pin_select =
            edge_capture_config_register[UTC_CAP_SEL_LSB + ch*UTC_SEL_W +: UTC_SEL_W];
         assign period_max =
            edge_capture_config_register[UTC_CAP_PER_LSB + ch*UTC_PER_W +: UTC_PER_W];
         assign falling_edge_select = edge_capture_config_register[UTC_CAP_FALL_BIT + ch];
         assign count_mode_enable = edge_capture_config_register[UTC_CAP_COUNT_EN_BIT + ch];
         assign interrupt_enable = edge_capture_config_register[UTC_CAP_IRQ_EN_BIT + ch];
         assign snapshot_source = edge_capture_config_register[UTC_CAP_STAMP_BIT + ch];

         // value 0 and values above the pin count select no pin
         always_comb begin
            cur = 1'b0;
            prv = 1'b0;
            for (int p = 0; p < UTC_NUM_PIN; p++) begin
               if (channel_pin_select == UTC_SEL_W'(p + 1)) begin
                  cur = pin_sync[p];
                  prv = pin_prev[p];
               end
            end
         end

         assign edge_seen = falling_edge_select ? (prv && !cur) : (!prv && cur);
         assign pending = channel_event_flag[ch] && !channel_event_clear[ch];
         // no groups complete while the timer is stopped
         assign group_done =
            running && count_mode_enable && edge_seen && (edge_count == period_max);
         assign take = count_mode_enable ? group_done : edge_seen;

         always_comb begin
            if (count_mode_enable) begin
               next_value = cycle_count + (tick ? RTC_W'(1) : RTC_W'(0));
            end else if (snapshot_source) begin
               next_value = rtc_value;
            end else begin
               next_value = RTC_W'(count);
            end
         end

         // edges counted per group, group of period_max plus one edges
         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               edge_count <= '0;
            end else if (!running || !count_mode_enable || group_done) begin
               edge_count <= '0;
            end else if (edge_seen) begin
               edge_count <= edge_count + 1'b1;
            end
         end

         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               cycle_count <= '0;
            end else if (!running || !count_mode_enable || group_done) begin
               cycle_count <= '0;
            end else if (tick) begin
               cycle_count <= cycle_count + 1'b1;
            end
         end

         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               channel_capture_count_value[ch] <= '0;
            end else if (take && !pending) begin
               channel_capture_count_value[ch] <= next_value;
            end
         end

         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               channel_event_flag[ch] <= 1'b0;
            end else if (take) begin
               channel_event_flag[ch] <= 1'b1;
            end else if (channel_event_clear[ch]) begin
               channel_event_flag[ch] <= 1'b0;
            end
         end

         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               channel_snapshot_overflow[ch] <= 1'b0;
            end else if (take && pending) begin
               channel_snapshot_overflow[ch] <= 1'b1;
            end else if (channel_event_clear[ch]) begin
               channel_snapshot_overflow[ch] <= 1'b0;
            end
         end

         assign ch_enabled_irq[ch] = channel_event_flag[ch] && interrupt_enable;
      end
   endgenerate

   // ****************************************
   // interrupt output
   // ****************************************
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= (timer_event_flag && timer_interrupt_enable) || (|ch_enabled_irq);
      end
   end

   // ****************************************
   // register read
   // ****************************************
   logic [UTC_DATA_W-1:0] next_rdata;

   always_comb begin
      next_rdata = '0;
      unique case (reg_addr)
         UTC_ADDR_CTRL: next_rdata = UTC_DATA_W'(updown_timer_control_register);
         UTC_ADDR_CAPTURE: next_rdata = UTC_DATA_W'(edge_capture_config_register);
         UTC_ADDR_STATUS: begin
            next_rdata[UTC_ST_EVENT_LSB +: UTC_NUM_CH] = channel_event_flag;
            next_rdata[UTC_ST_OVF_LSB +: UTC_NUM_CH] = channel_snapshot_overflow;
            next_rdata[UTC_ST_TIMER_BIT] = timer_event_flag;
         end
         UTC_ADDR_CAPCNT1: next_rdata = UTC_DATA_W'(channel_capture_count_value[0]);
         UTC_ADDR_CAPCNT2: next_rdata = UTC_DATA_W'(channel_capture_count_value[1]);
         UTC_ADDR_COUNTER: next_rdata = UTC_DATA_W'(count);
         default: next_rdata = '0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule

// ==== bench/utc_timer_sva.sv ====
// checker of register port and interrupt timing
`timescale 1ns/1ps
module utc_timer_sva import utc_pkg::*; #(
   parameter int CNT_W = UTC_CNT_W,
   parameter int RTC_W = UTC_RTC_W
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [UTC_ADDR_W-1:0] reg_addr,
   input wire logic [UTC_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [UTC_DATA_W-1:0] reg_rdata,
   input wire logic low_power_clock,
   input wire logic [UTC_NUM_PIN-1:0] port0_pin,
   input wire logic [RTC_W-1:0] rtc_value,
   input wire logic irq
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   sequence s_ctrl_wr;
      reg_wr && reg_addr == UTC_ADDR_CTRL;
   endsequence
   sequence s_start_r2;
      s_ctrl_wr ##0 reg_wdata == 32'h0001_D002;
   endsequence
   sequence s_stop_up;
      s_ctrl_wr ##0 (!reg_wdata[16] && !reg_wdata[11]);
   endsequence
   a_rdata_idle: assert property (
      !reg_rd |=> reg_rdata == '0) else $error("read data without a read");
   a_clear_reads_zero: assert property (
      reg_rd && reg_addr == UTC_ADDR_CLR_EVENT |=> reg_rdata == '0)
      else $error("clear register read not zero");
   a_counter_width: assert property (
      reg_rd && reg_addr == UTC_ADDR_COUNTER |=> reg_rdata[UTC_DATA_W-1:CNT_W] == '0)
      else $error("counter wider than its field");
   a_snapshot_width: assert property (
      reg_rd && (reg_addr == UTC_ADDR_CAPCNT1 || reg_addr == UTC_ADDR_CAPCNT2)
      |=> reg_rdata[UTC_DATA_W-1:RTC_W] == '0) else $error("snapshot too wide");
   a_status_width: assert property (
      reg_rd && reg_addr == UTC_ADDR_STATUS |=> reg_rdata[UTC_DATA_W-1:5] == '0)
      else $error("status has stray bits");
   a_timer_walk: assert property (
      s_start_r2 ##1 (!reg_wr) [*3] |=> irq) else $error("timer irq late");
   a_idle_held: assert property (
      s_stop_up ##1 !reg_wr ##1 (reg_rd && reg_addr == UTC_ADDR_COUNTER)
      |=> reg_rdata == '0) else $error("stopped counter not zero");
   a_ctrl_readback: assert property (
      s_ctrl_wr ##1 !reg_wr ##1 (reg_rd && reg_addr == UTC_ADDR_CTRL)
      |=> reg_rdata == ($past(reg_wdata, 3) & 32'h0001_FFFF))
      else $error("control readback wrong");
   a_irq_holds: assert property (
      irq && !reg_wr && !$past(reg_wr) |=> irq) else $error("irq dropped uncleared");
endmodule
bind utc_timer utc_timer_sva #(.CNT_W(CNT_W), .RTC_W(RTC_W)) u_sva (.clk_sys, .arst_n,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .low_power_clock, .port0_pin,
   .rtc_value, .irq);

// ==== bench/utc_far_end.sv ====
// far side model: port-0 pins, RTC port, low-power clock
`timescale 1ns/1ps
module utc_far_end import utc_pkg::*; (
   input wire logic clk_sys,
   output logic [UTC_NUM_PIN-1:0] port0_pin,
   output logic [UTC_RTC_W-1:0] rtc_value,
   output logic low_power_clock
);
   logic lp_run;
   logic [1:0] lp_div;
   initial begin
      port0_pin = '0;
      rtc_value = '0;
      low_power_clock = 1'b0;
      lp_run = 1'b0;
      lp_div = 2'h0;
   end
   // slow clock stands still unless let run, one toggle per four edges
   always @(posedge clk_sys) begin
      lp_div <= lp_div + 2'h1;
      if (lp_run && lp_div == 2'h3) low_power_clock <= ~low_power_clock;
   end
   task automatic train(input int idx, input int n, input int gap);
      repeat (n) begin
         @(posedge clk_sys);
         port0_pin[idx] <= 1'b1;
         repeat (gap / 2) @(posedge clk_sys);
         port0_pin[idx] <= 1'b0;
         repeat (gap / 2 - 1) @(posedge clk_sys);
      end
   endtask
   task automatic set_rtc(input logic [UTC_RTC_W-1:0] x);
      @(posedge clk_sys);
      rtc_value <= x;
   endtask
endmodule

// ==== bench/test_utc_timer.sv ====
// self-checking bench of the up/down timer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
   fail_count++; $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module test_utc_timer import utc_pkg::*; ;
   logic clk_sys, arst_n, reg_wr, reg_rd, irq, low_power_clock;
   logic [UTC_ADDR_W-1:0] reg_addr;
   logic [UTC_DATA_W-1:0] reg_wdata, reg_rdata, d;
   logic [UTC_DATA_W-1:0] v [3];
   logic [UTC_NUM_PIN-1:0] port0_pin;
   logic [UTC_RTC_W-1:0] rtc_value;
   int fail_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   localparam logic [31:0] RUNS = 32'h0001_C000;
   localparam logic [31:0] DN = 32'h0000_0800;
   localparam logic [31:0] IRQE = 32'h0000_1000;
   utc_timer DUT (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .low_power_clock, .port0_pin, .rtc_value, .irq);
   utc_far_end PTR (.clk_sys, .port0_pin, .rtc_value, .low_power_clock);
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] x);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= x;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      d = reg_rdata;
   endtask
   task automatic cr(input logic [7:0] a, input logic [31:0] ex, input string nm);
      rd(a);
      `CHK(nm, ex, d)
   endtask
   task automatic poll(input logic [31:0] m);
      d = '0;
      for (int n = 0; n < 2000 && (d & m) == '0; n++) rd(UTC_ADDR_STATUS);
   endtask
   task automatic give_verdict();
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      arst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      repeat (5) @(posedge clk_sys);
      arst_n <= 1'b1;
      cr(UTC_ADDR_CTRL, UTC_CTRL_RESET, "ctrl");
      cr(UTC_ADDR_CAPTURE, UTC_CAP_RESET, "capture");
      wr(UTC_ADDR_STATUS, 32'hFFFF_FFFF);
      cr(UTC_ADDR_STATUS, 32'h0, "status");
      cr(8'h1C, 32'h0, "unmapped");
      wr(UTC_ADDR_CTRL, 32'hFFFE_27FF);
      cr(UTC_ADDR_CTRL, 32'h0000_27FF, "ctrl");
      $display("test register_map done");
      wr(UTC_ADDR_CTRL, RUNS | IRQE | 32'h2);
      poll(32'h10);
      `CHK("status", 32'h10, d)
      `CHK("irq", 1'b1, irq)
      wr(UTC_ADDR_CTRL, IRQE | 32'h2);
      cr(UTC_ADDR_COUNTER, 32'h0, "count");
      wr(UTC_ADDR_CLR_EVENT, 32'h4);
      cr(UTC_ADDR_STATUS, 32'h0, "status");
      `CHK("irq", 1'b0, irq)
      $display("test count_up done");
      wr(UTC_ADDR_CTRL, RUNS | DN | 32'h5);
      poll(32'h10);
      `CHK("irq", 1'b0, irq)
      wr(UTC_ADDR_CTRL, DN | 32'h5);
      cr(UTC_ADDR_COUNTER, 32'h5, "count");
      wr(UTC_ADDR_CLR_EVENT, 32'h4);
      $display("test count_down done");
      wr(UTC_ADDR_CTRL, 32'h0001_9803);
      repeat (40) @(posedge clk_sys);
      cr(UTC_ADDR_STATUS, 32'h0, "status");
      PTR.lp_run = 1'b1;
      poll(32'h10);
      `CHK("status", 32'h10, d)
      PTR.lp_run = 1'b0;
      wr(UTC_ADDR_CTRL, 32'h0);
      wr(UTC_ADDR_CLR_EVENT, 32'h4);
      $display("test slow_clock done");
      wr(UTC_ADDR_CTRL, RUNS | 32'h2003);
      repeat (20) @(posedge clk_sys);
      cr(UTC_ADDR_STATUS, 32'h0, "status");
      poll(32'h10);
      `CHK("status", 32'h10, d)
      wr(UTC_ADDR_CTRL, 32'h0);
      wr(UTC_ADDR_CLR_EVENT, 32'h4);
      $display("test free_run done");
      wr(UTC_ADDR_CTRL, DN | 32'h5A3);
      for (int s = 0; s < 13; s++) begin
         wr(UTC_ADDR_CAPTURE, IRQE | 32'(s));
         PTR.train((s == 0) ? 0 : s - 1, 1, 6);
         repeat (4) @(posedge clk_sys);
         cr(UTC_ADDR_STATUS, {31'h0, s != 0}, "status");
         cr(UTC_ADDR_CAPCNT1, (s != 0) ? 32'h5A3 : 32'h0, "snapshot");
         `CHK("irq", s != 0, irq)
         wr(UTC_ADDR_CLR_EVENT, 32'h3);
      end
      wr(UTC_ADDR_CAPTURE, 32'h1);
      PTR.train(0, 1, 6);
      repeat (4) @(posedge clk_sys);
      cr(UTC_ADDR_STATUS, 32'h1, "status");
      `CHK("irq", 1'b0, irq)
      wr(UTC_ADDR_CLR_EVENT, 32'h1);
      $display("test pin_select done");
      wr(UTC_ADDR_CAPTURE, 32'h0000_B233);
      PTR.set_rtc(22'h2A5C3B);
      PTR.train(2, 1, 6);
      repeat (4) @(posedge clk_sys);
      cr(UTC_ADDR_STATUS, 32'h3, "status");
      cr(UTC_ADDR_CAPCNT2, 32'h002A_5C3B, "rtc stamp");
      wr(UTC_ADDR_CTRL, DN | 32'h111);
      PTR.set_rtc(22'h001234);
      PTR.train(2, 1, 6);
      repeat (4) @(posedge clk_sys);
      cr(UTC_ADDR_STATUS, 32'hF, "status");
      cr(UTC_ADDR_CAPCNT1, 32'h5A3, "kept");
      cr(UTC_ADDR_CAPCNT2, 32'h002A_5C3B, "kept");
      wr(UTC_ADDR_CLR_EVENT, 32'h1);
      cr(UTC_ADDR_STATUS, 32'hA, "status");
      `CHK("irq", 1'b1, irq)
      wr(UTC_ADDR_CLR_EVENT, 32'h2);
      cr(UTC_ADDR_STATUS, 32'h0, "status");
      `CHK("irq", 1'b0, irq)
      $display("test overflow done");
      wr(UTC_ADDR_CTRL, RUNS | 32'h2000);
      wr(UTC_ADDR_CAPTURE, 32'h0002_1404);
      fork
         begin
            PTR.train(3, 6, 10);
            PTR.train(3, 3, 20);
         end
      join_none
      for (int i = 0; i < 3; i++) begin
         poll(32'h1);
         rd(UTC_ADDR_CAPCNT1);
         v[i] = d;
         wr(UTC_ADDR_CLR_EVENT, 32'h1);
      end
      `CHK("group delta", 32'd20, v[2] - v[1])
      `CHK("group cycles", 32'h1E, v[1])
      cr(UTC_ADDR_STATUS, 32'h0, "status");
      $display("test counting done");
      give_verdict();
   end
endmodule
